// ===== fram_host.sv
// Host controller driving the parallel nonvolatile memory pins
`timescale 1ns/1ps
`default_nettype none
module fram_host
  import fram_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire req_t req_i,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output pins_t pins_o,
  input wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_lines_oe_n_o
);
  typedef struct packed {
    state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gap;
    logic row_open;
    logic [ROW_W-1:0] row;
    req_t cur;
    pins_t pins;
    logic drive;
    logic [DATA_W-1:0] wdata;
    logic rsp_valid;
    logic [DATA_W-1:0] rdata;
  } regs_t;

  localparam regs_t RESET_REGS = '{
    st: ST_IDLE, cnt: '0, gap: '0, row_open: 1'b0, row: '0, cur: '0,
    pins: '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_drive_n: 1'b1,
            upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1,
            sleep_request_n: 1'b1, addr: '0},
    drive: 1'b0, wdata: '0, rsp_valid: 1'b0, rdata: '0};

  function automatic logic [CNT_W-1:0] to_cnt(input int n);
    return n[CNT_W-1:0];
  endfunction

  regs_t r;
  regs_t next_r;
  logic same_row;

  assign same_row = r.row_open && (req_i.addr[ADDR_W-1:COL_W] == r.row) && !req_i.sleep;
  // Take a request only when idle and either the random-cycle spacing has elapsed or it hits the open row
  assign req_ready_o = (r.st == ST_IDLE) && (same_row || r.gap == '0);

  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    if (r.gap != '0) begin
      next_r.gap = r.gap - to_cnt(1);
    end
    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - to_cnt(1);
    end
    unique case (r.st)
      ST_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          next_r.cur = req_i;
          if (req_i.sleep) begin
            // All accesses are finished here, so sleep is safe to enter
            next_r.pins.chip_select_n = 1'b1;
            next_r.pins.sleep_request_n = 1'b0;
            next_r.row_open = 1'b0;
            next_r.st = ST_SLEEP;
          end else if (same_row) begin
            // Column change only: stay in the open row
            next_r.pins.addr = req_i.addr;
            next_r.pins.upper_byte_sel_n = req_i.byte_en_n[1];
            next_r.pins.lower_byte_sel_n = req_i.byte_en_n[0];
            next_r.pins.output_drive_n = req_i.wr;
            next_r.pins.write_strobe_n = !req_i.wr;
            next_r.drive = req_i.wr;
            next_r.wdata = req_i.wdata;
            next_r.cnt = to_cnt(req_i.wr ? ACCESS_CYC : PAGE_CYC);
            next_r.st = ST_ACCESS;
          end else begin
            // New row: precharge with select high first
            next_r.pins.chip_select_n = 1'b1;
            next_r.pins.write_strobe_n = 1'b1;
            next_r.pins.output_drive_n = 1'b1;
            next_r.drive = 1'b0;
            next_r.row_open = 1'b0;
            next_r.cnt = to_cnt(PC_CYC);
            next_r.st = ST_PRECHG;
          end
        end
      end
      ST_PRECHG: begin
        if (r.cnt == to_cnt(1)) begin
          next_r.pins.addr = r.cur.addr;
          next_r.pins.upper_byte_sel_n = r.cur.byte_en_n[1];
          next_r.pins.lower_byte_sel_n = r.cur.byte_en_n[0];
          next_r.pins.chip_select_n = 1'b0;
          // Strobe low at select fall gives a select-controlled write
          next_r.pins.write_strobe_n = !r.cur.wr;
          next_r.pins.output_drive_n = r.cur.wr;
          next_r.drive = r.cur.wr;
          next_r.wdata = r.cur.wdata;
          next_r.row_open = 1'b1;
          next_r.row = r.cur.addr[ADDR_W-1:COL_W];
          next_r.gap = to_cnt(r.cur.wr ? WC_CYC : RC_CYC);
          next_r.cnt = to_cnt(ACCESS_CYC);
          next_r.st = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (r.cnt == to_cnt(1)) begin
          if (r.cur.wr) begin
            // Strobe rise ends the write with data held stable
            next_r.pins.write_strobe_n = 1'b1;
            next_r.st = ST_WR_HOLD;
          end else begin
            next_r.rdata = data_lines_i;
            next_r.rsp_valid = 1'b1;
            next_r.pins.output_drive_n = 1'b1;
            next_r.st = ST_IDLE;
          end
        end
      end
      ST_WR_HOLD: begin
        // One cycle of data hold after the strobe rises
        next_r.drive = 1'b0;
        next_r.rsp_valid = 1'b1;
        next_r.st = ST_DONE;
      end
      ST_DONE: begin
        next_r.st = ST_IDLE;
      end
      ST_SLEEP: begin
        if (req_valid_i && !req_i.sleep) begin
          next_r.pins.sleep_request_n = 1'b1;
          next_r.cnt = to_cnt(SLEEP_EXIT_CYC);
          next_r.st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (r.cnt == to_cnt(1)) begin
          next_r.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= RESET_REGS;
    end else begin
      r <= next_r;
    end
  end

  assign pins_o = r.pins;
  assign data_lines_o = r.wdata;
  assign data_lines_oe_n_o = !r.drive;
  assign rsp_valid_o = r.rsp_valid;
  assign rsp_data_o = r.rdata;

  // Read opens with select falling while the strobe stays high
  sequence s_read_open;
    $fell(r.pins.chip_select_n) && r.pins.write_strobe_n;
  endsequence
  // Read data is taken once access time plus setup have run
  sequence s_read_done;
    ##2 rsp_valid_o;
  endsequence
  sequence s_strobe_fall;
    $fell(r.pins.write_strobe_n);
  endsequence

  a_sleep_no_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !r.pins.sleep_request_n |-> r.pins.chip_select_n)
    else $error("select low during sleep");
  a_sleep_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(r.pins.sleep_request_n) |->
      r.pins.write_strobe_n && r.pins.output_drive_n && !r.drive)
    else $error("sleep entered during an access");
  a_precharge_state: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    r.st == ST_PRECHG |-> r.pins.chip_select_n)
    else $error("select low during precharge");
  a_precharge_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(r.pins.chip_select_n) |-> $past(r.st) == ST_PRECHG)
    else $error("select fell without precharge");
  a_row_spacing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(r.pins.chip_select_n) |-> $past(r.gap) == '0)
    else $error("new row before the random cycle time");
  a_page_row_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !r.pins.chip_select_n && $stable(r.pins.chip_select_n) && $changed(r.pins.addr) |->
      $stable(r.pins.addr[ADDR_W-1:COL_W]))
    else $error("row changed while select held low");
  a_no_contention: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    r.drive |-> r.pins.output_drive_n)
    else $error("host drives while output enabled");
  a_strobe_no_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !r.pins.write_strobe_n |-> r.pins.output_drive_n)
    else $error("output enabled during a write");
  a_strobe_is_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_strobe_fall |-> r.cur.wr)
    else $error("strobe pulse without a write");
  a_strobe_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_strobe_fall |-> !r.pins.write_strobe_n [*2])
    else $error("write strobe too short");
  a_strobe_ends: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_strobe_fall |-> ##[1:4] r.pins.write_strobe_n)
    else $error("write strobe held low");
  a_write_data_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !r.pins.write_strobe_n && !$fell(r.pins.write_strobe_n) |->
      r.drive && $stable(r.wdata))
    else $error("write data moved during the strobe");
  a_data_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(r.pins.write_strobe_n) |-> r.drive)
    else $error("write data not held at strobe rise");
  a_wake_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(r.pins.sleep_request_n) |-> r.pins.chip_select_n [*8] ##1 r.pins.chip_select_n)
    else $error("access too soon after wake");
  a_read_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_read_open |-> s_read_done)
    else $error("read answer late");
endmodule
`default_nettype wire

// ===== fram_host_pkg.sv
// Constants and carrier types for the parallel nonvolatile memory host controller
// Overview of operation
// - A new row opens only by select falling or row address changing.
// - Host gives every write its own separate low strobe pulse.
// - Random row accesses are spaced at least the random read cycle time.
// - Strobe low at select fall makes a write; host data valid at strobe rise.
// - Host holds write for access time and data stable for setup before end.
// - Host holds select high at least the precharge time.
// - Host finishes accesses before sleep; device ignores pins while asleep.
// - Host waits the sleep exit delay after leaving sleep before any access.
package fram_host_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int COL_W = 2;
  localparam int ROW_W = ADDR_W - COL_W;
  localparam int CLK_PERIOD_NS = 50;
  // Figures in ns
  localparam int ACCESS_TIME_NS = 60;
  localparam int RANDOM_READ_CYCLE_TIME_NS = 90;
  localparam int RANDOM_WRITE_CYCLE_TIME_NS = 90;
  localparam int PRECHARGE_MIN_TIME_NS = 30;
  localparam int PAGE_ACCESS_TIME_NS = 25;
  localparam int DATA_SETUP_NS = 20;
  localparam int SLEEP_EXIT_DELAY_NS = 450;
  // Least times round up, at least one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int ACCESS_CYC = cyc_up(ACCESS_TIME_NS + DATA_SETUP_NS);
  localparam int RC_CYC = cyc_up(RANDOM_READ_CYCLE_TIME_NS);
  localparam int WC_CYC = cyc_up(RANDOM_WRITE_CYCLE_TIME_NS);
  localparam int PC_CYC = cyc_up(PRECHARGE_MIN_TIME_NS);
  localparam int PAGE_CYC = cyc_up(PAGE_ACCESS_TIME_NS);
  localparam int SLEEP_EXIT_CYC = cyc_up(SLEEP_EXIT_DELAY_NS);
  localparam int CNT_W = 8;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PRECHG = 7'h02,
    ST_ACCESS = 7'h04,
    ST_WR_HOLD = 7'h08,
    ST_DONE = 7'h10,
    ST_SLEEP = 7'h20,
    ST_WAKE = 7'h40
  } state_t;

  typedef struct packed {
    logic wr;
    logic sleep;
    logic [1:0] byte_en_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_drive_n;
    logic upper_byte_sel_n;
    logic lower_byte_sel_n;
    logic sleep_request_n;
    logic [ADDR_W-1:0] addr;
  } pins_t;
endpackage

// ===== fram_model.sv
// Behavioural model of the parallel nonvolatile memory device
`timescale 1ns/1ps
`default_nettype none
module fram_model
  import fram_host_pkg::*;
(
  input wire pins_t pins_i,
  input wire logic [DATA_W-1:0] host_data_i,
  input wire logic host_oe_n_i,
  output logic [DATA_W-1:0] bus_o
);
  logic [DATA_W-1:0] mem [0:65535];
  logic [DATA_W-1:0] last = 16'h0000;
  logic [DATA_W-1:0] d;
  logic [ADDR_W-1:0] pa = 16'h0000;
  logic pcs = 1'b1;
  logic pwe = 1'b1;
  logic wr_act = 1'b0;
  logic rd;
  realtime valid_at = 0;
  wire logic cs = pins_i.chip_select_n;
  wire logic we = pins_i.write_strobe_n;
  wire logic [ADDR_W-1:0] a = pins_i.addr;
  // Sampled on a 1 ns grid so that simultaneous pin edges resolve in one pass
  always #1 begin
    if (pins_i.sleep_request_n) begin
      if (!cs && (pcs || a[ADDR_W-1:COL_W] != pa[ADDR_W-1:COL_W])) begin
        valid_at = $realtime + ACCESS_TIME_NS;
      end else if (a != pa) begin
        valid_at = $realtime + PAGE_ACCESS_TIME_NS;
      end
      if (!cs && !we && (pcs || pwe)) wr_act = 1'b1;
      if (wr_act && (cs || we)) begin
        if (!pins_i.upper_byte_sel_n) mem[pa][15:8] = last[15:8];
        if (!pins_i.lower_byte_sel_n) mem[pa][7:0] = last[7:0];
        wr_act = 1'b0;
      end
    end
    pcs = cs;
    pwe = we;
    pa = a;
    rd = pins_i.sleep_request_n && !cs && !pins_i.output_drive_n && we && $realtime >= valid_at;
    d = mem[a];
    // Released bytes show a toggling pattern rather than the last value
    bus_o[15:8] = (rd && !pins_i.upper_byte_sel_n) ? d[15:8] : ~last[15:8];
    bus_o[7:0] = (rd && !pins_i.lower_byte_sel_n) ? d[7:0] : ~last[7:0];
    if (!host_oe_n_i) bus_o = host_data_i;
    last = bus_o;
  end
endmodule
`default_nettype wire

// ===== tb_fram_host.sv
// Self-checking testbench for the memory host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_fram_host;
  import fram_host_pkg::*;
  localparam int RD_NEW = 1 + PC_CYC + ACCESS_CYC;
  localparam int RD_PG = 1 + PAGE_CYC;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  req_t req_i = '0;
  logic req_ready_o, rsp_valid_o, data_lines_oe_n_o;
  logic [DATA_W-1:0] rsp_data_o, data_lines_o, bus;
  pins_t pins_o;
  int err_count = 0;
  int checks = 0;
  always #25 clk_i = ~clk_i;
  fram_host uut(.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .pins_o(pins_o), .data_lines_i(bus),
    .data_lines_o(data_lines_o), .data_lines_oe_n_o(data_lines_oe_n_o));
  fram_model dev(.pins_i(pins_o), .host_data_i(data_lines_o),
    .host_oe_n_i(data_lines_oe_n_o), .bus_o(bus));
  // The host may only drive while the device is barred from driving
  always @(negedge clk_i) begin
    if (rst_n_i && !data_lines_oe_n_o) `CHK(~pins_o.output_drive_n & pins_o.write_strobe_n, 1'b0)
  end
  task results;
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task take(input req_t r, output int lat);
    int n;
    @(posedge clk_i);
    req_i <= r;
    req_valid_i <= 1'b1;
    n = 0;
    do begin @(negedge clk_i); n++; end while (req_ready_o !== 1'b1 && n < 60);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    lat = 0;
    do begin @(negedge clk_i); lat++; end while (rsp_valid_o !== 1'b1 && lat < 30);
  endtask
  task acc(input logic w, input logic [1:0] be, input logic [15:0] a, input logic [15:0] dv,
    input int el);
    int lat;
    take({w, 1'b0, be, a, dv}, lat);
    if (!w) `CHK(rsp_data_o, dv)
    if (el > 0) `CHK(lat, el)
  endtask
  task t_rows;
    acc(1'b1, 2'b00, 16'h1234, 16'hA5C3, RD_NEW + 1);
    acc(1'b1, 2'b00, 16'h5678, 16'h3C5A, RD_NEW + 1);
    acc(1'b0, 2'b00, 16'h1234, 16'hA5C3, RD_NEW);
    acc(1'b0, 2'b00, 16'h5678, 16'h3C5A, RD_NEW);
  endtask
  task t_page;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 2'b00, 16'h2000 + i[15:0], 16'h0F00 + i[15:0],
        (i == 0) ? RD_NEW + 1 : ACCESS_CYC + 2);
    end
    acc(1'b0, 2'b00, 16'h2002, 16'h0F02, 0);
    acc(1'b0, 2'b00, 16'h2000, 16'h0F00, RD_PG);
    acc(1'b0, 2'b00, 16'h2003, 16'h0F03, RD_PG);
  endtask
  task t_bytes;
    acc(1'b1, 2'b01, 16'h1234, 16'hFFFF, 0);
    acc(1'b1, 2'b10, 16'h1234, 16'h0000, 0);
    acc(1'b0, 2'b00, 16'h1234, 16'hFF00, 0);
  endtask
  task t_sleep;
    int lat;
    take({1'b0, 1'b1, 2'b00, 16'h0000, 16'h0000}, lat);
    `CHK(pins_o.sleep_request_n, 1'b0)
    take({1'b0, 1'b0, 2'b00, 16'h5678, 16'h0000}, lat);
    `CHK(rsp_data_o, 16'h3C5A)
    acc(1'b0, 2'b00, 16'h5678, 16'h3C5A, 0);
    `CHK(pins_o.sleep_request_n, 1'b1)
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    `CHK({pins_o.chip_select_n, pins_o.write_strobe_n, pins_o.sleep_request_n}, 3'h7)
    `CHK(data_lines_oe_n_o, 1'b1)
    rst_n_i <= 1'b1;
    t_rows();
    t_page();
    t_bytes();
    t_sleep();
    results();
  end
  initial begin
    #(CLK_PERIOD_NS * 5000);
    err_count++;
    results();
  end
endmodule
`default_nettype wire
